// *** supply_trim_track_servo.sv ***
// Purpose: Two-channel trim DAC control with tracking and voltage servo
// Assumes: ADC, limit checks and soft connect search live outside
// Notes:   Operation
`timescale 1ns/1ps
module supply_trim_track_servo #(
	parameter int STEP_CYC   = trim_track_pkg::TRACK_STEP_CYC,
	parameter int HOLD_CYC   = trim_track_pkg::TRACK_HOLD_CYC,
	parameter int SETTLE_CYC = trim_track_pkg::TRACK_SETTLE_CYC,
	parameter int SYNC_CYC   = trim_track_pkg::SYNC_WAIT_CYC
) (
	input  wire logic              ref_clk_i,
	input  wire logic              reset_i,
	trim_link_if.dev               link,
	input  wire logic              adc_done_i,
	input  wire logic              adc_ch_i,
	input  wire logic [14:0]       adc_value_i,
	input  wire logic              adc_busy_i,
	input  wire logic [1:0]        volt_fault_i,
	input  wire logic [1:0]        soft_conn_i,
	input  wire logic              cfg_i,
	input  wire logic [1:0]        run_i,
	output logic      [1:0][7:0]   trim_code_o,
	output logic      [1:0]        trim_oe_o,
	output logic      [1:0]        idac_fault_o,
	output logic                   adc_fast_o,
	output logic                   adc_hold_others_o,
	output logic                   adc_hold_all_o,
	output logic      [1:0]        run_o,
	output logic      [1:0]        run_oe_o,
	output logic                   cfg_o,
	output logic                   cfg_oe_o
);

	typedef struct packed {
		logic [1:0][7:0]  code;
		logic [1:0][7:0]  trk_tgt;
		logic [1:0][7:0]  delay;
		logic [1:0][14:0] servo_tgt;
		logic [1:0][1:0]  fine;
		logic [1:0]       pol;
		logic [1:0]       con;
		logic [1:0]       en;
		logic [1:0]       oe;
		logic [1:0]       trk_pol;
		logic [1:0]       trk_en;
		logic [1:0]       trk_mask;
		logic [1:0]       servo_en;
		logic [1:0]       done;
		logic [1:0]       rpt;
		logic [1:0]       retrig;
		logic [1:0]       fault;
		logic [1:0]       run_pull;
		logic             cfg_low;
		logic             up;
		logic             fast;
		logic             hold_oth;
		logic             hold_all;
		trim_track_pkg::phase_t phase;
		logic [11:0]      tmr;
		logic [11:0]      tick;
		logic [15:0]      rdata;
	} state_t;

	state_t             s;
	state_t             n;
	logic               busy;
	logic               rng;
	logic               wr;
	logic               srv_step;
	logic [3:0]         a;
	logic [15:0]        d;
	logic signed [14:0] v;
	logic signed [14:0] t;

	assign trim_code_o       = s.code;
	assign trim_oe_o         = s.oe;
	assign idac_fault_o      = s.fault;
	assign adc_fast_o        = s.fast;
	assign adc_hold_others_o = s.hold_oth;
	assign adc_hold_all_o    = s.hold_all;
	assign run_o             = 2'h0;
	assign run_oe_o          = s.run_pull;
	assign cfg_o             = 1'h0;
	assign cfg_oe_o          = s.cfg_low;
	assign link.rdata        = s.rdata;

	always_comb begin
		n        = s;
		wr       = link.wr;
		a        = link.addr;
		d        = link.wdata;
		v        = $signed(adc_value_i);
		t        = '0;
		srv_step = 1'b0;
		busy     = s.phase != trim_track_pkg::PH_IDLE;
		rng      = cfg_i & (|run_i);
		if (wr && a == trim_track_pkg::A_IO) begin
			n.run_pull = ~d[1:0];
		end
		if (wr && a == trim_track_pkg::A_SERVO_OPT) begin
			n.rpt    = d[1:0];
			n.retrig = d[3:2];
		end
		if (wr && a == trim_track_pkg::A_SYNC && d[trim_track_pkg::SYNC_REQ] && !busy) begin
			n.phase = trim_track_pkg::PH_SYNC_FINISH;
		end
		unique case (s.phase)
			trim_track_pkg::PH_IDLE: begin
			end
			trim_track_pkg::PH_SYNC_FINISH: begin
				if (!adc_busy_i) begin
					n.phase = trim_track_pkg::PH_SYNC_WAIT;
					n.tmr   = '0;
				end
			end
			trim_track_pkg::PH_SYNC_WAIT: begin
				n.tmr = s.tmr + 12'h001;
				if (s.tmr == 12'(SYNC_CYC - 1)) begin
					n.phase = trim_track_pkg::PH_IDLE;
				end
			end
			trim_track_pkg::PH_SETTLE: begin
				n.tmr = s.tmr + 12'h001;
				if (s.tmr == 12'(SETTLE_CYC - 1)) begin
					n.phase = trim_track_pkg::PH_STEP;
					n.tick  = '0;
				end
			end
			trim_track_pkg::PH_STEP: begin
				n.tick = s.tick + 12'h001;
				if (s.trk_en == 2'h0) begin
					n.phase   = s.up ? trim_track_pkg::PH_HOLD : trim_track_pkg::PH_IDLE;
					n.cfg_low = s.up;
					n.tmr     = '0;
				end else if (s.tick == 12'(STEP_CYC - 1)) begin
					n.tick = '0;
					for (int c = 0; c < 2; c++) begin
						if (s.trk_en[c]) begin
							if (s.delay[c] != 8'h00) begin
								n.delay[c] = s.delay[c] - 8'h01;
							end else if (s.code[c] < s.trk_tgt[c]) begin
								n.code[c] = s.code[c] + 8'h01;
							end else if (s.code[c] > s.trk_tgt[c]) begin
								n.code[c] = s.code[c] - 8'h01;
							end else begin
								n.trk_en[c] = 1'b0;
							end
						end
					end
				end
			end
			trim_track_pkg::PH_HOLD: begin
				n.tmr = s.tmr + 12'h001;
				if (s.tmr == 12'(HOLD_CYC - 1)) begin
					n.en    = s.en & ~s.trk_mask;
					n.con   = s.con & ~s.trk_mask;
					n.phase = trim_track_pkg::PH_IDLE;
				end
			end
		endcase
		if (wr && a == trim_track_pkg::A_IO && d[trim_track_pkg::IO_START]
			&& (s.phase == trim_track_pkg::PH_IDLE || s.phase == trim_track_pkg::PH_SYNC_WAIT)) begin
			if (cfg_i) begin
				if ((s.trk_en & ~s.con) == 2'h0) begin
					n.up       = 1'b1;
					n.trk_mask = s.trk_en;
					n.phase    = trim_track_pkg::PH_STEP;
					n.tick     = '0;
				end
			end else if ((s.trk_en & s.en) == 2'h0) begin
				n.up       = 1'b0;
				n.trk_mask = s.trk_en;
				n.en       = s.en | s.trk_en;
				n.con      = s.con | s.trk_en;
				n.cfg_low  = 1'b0;
				n.phase    = trim_track_pkg::PH_SETTLE;
				n.tmr      = '0;
			end
		end
		n.fast     = 1'b0;
		n.hold_oth = 1'b0;
		for (int c = 0; c < 2; c++) begin
			if (wr && a == 4'(trim_track_pkg::A_IDAC0 + c) && !rng) begin
				if (!d[trim_track_pkg::IDAC_EN]) begin
					n.en[c]  = 1'b0;
					n.con[c] = 1'b0;
				end else begin
					n.en[c] = 1'b1;
					if (!busy && !s.servo_en[c]) begin
						n.code[c] = d[7:0];
						n.pol[c]  = d[trim_track_pkg::IDAC_POL];
						if (d[trim_track_pkg::IDAC_CON]) begin
							n.con[c] = 1'b1;
						end
					end
				end
			end
			if (soft_conn_i[c] && s.en[c]) begin
				n.con[c] = 1'b1;
			end
			if (wr && a == 4'(trim_track_pkg::A_TRACK0 + c) && !busy && !rng) begin
				n.trk_tgt[c] = d[7:0];
				n.trk_pol[c] = d[trim_track_pkg::TRK_POL];
				n.trk_en[c]  = d[trim_track_pkg::TRK_EN];
			end
			if (wr && a == 4'(trim_track_pkg::A_DELAY0 + c) && !busy) begin
				n.delay[c] = d[7:0];
			end
			if (wr && a == 4'(trim_track_pkg::A_SERVO0 + c)) begin
				n.servo_tgt[c] = d[14:0];
				n.servo_en[c]  = d[trim_track_pkg::SERVO_EN] & s.con[c];
				n.done[c]      = 1'b0;
				n.fine[c]      = 2'h0;
			end
			if (volt_fault_i[c] && s.retrig[c] && s.servo_en[c]) begin
				n.done[c] = 1'b0;
				n.fine[c] = 2'h0;
			end
			srv_step = adc_done_i && adc_ch_i == c[0] && s.servo_en[c] && s.con[c] && !busy
				&& (s.rpt[c] || !s.done[c]);
			if (srv_step) begin
				t = $signed(s.servo_tgt[c]);
				if (v < t && s.code[c] != 8'hFF) begin
					n.code[c] = s.code[c] + 8'h01;
				end else if (v > t && s.code[c] != 8'h00) begin
					n.code[c] = s.code[c] - 8'h01;
				end
				if (!s.done[c]) begin
					if (s.fine[c] == 2'h0) begin
						n.fine[c] = {1'b0, v == t};
					end else if (s.fine[c] == trim_track_pkg::FINE_CONVS) begin
						n.done[c] = 1'b1;
						n.fine[c] = 2'h0;
					end else begin
						n.fine[c] = s.fine[c] + 2'h1;
					end
				end
			end
			if (!n.en[c] || busy || rng) begin
				n.servo_en[c] = 1'b0;
			end
			n.oe[c]    = n.en[c] & n.con[c];
			n.fault[c] = n.code[c] == 8'hFF || n.code[c] == 8'h00;
			n.fast     = n.fast | (n.servo_en[c] & ~n.done[c] & (n.fine[c] == 2'h0));
			n.hold_oth = n.hold_oth | (n.servo_en[c] & ~n.done[c]);
		end
		n.hold_all = n.phase != trim_track_pkg::PH_IDLE;
		n.rdata    = '0;
		if (link.rd) begin
			unique case (a)
				4'h0, 4'h1: n.rdata = {5'h00, s.en[a[0]], s.con[a[0]], s.pol[a[0]], s.code[a[0]]};
				4'h2, 4'h3: n.rdata = {6'h00, s.trk_en[a[0]], s.trk_pol[a[0]], s.trk_tgt[a[0]]};
				4'h4, 4'h5: n.rdata = {8'h00, s.delay[a[0]]};
				4'h6, 4'h7: n.rdata = {s.servo_en[a[0]], s.servo_tgt[a[0]]};
				4'h8: n.rdata = {10'h000, cfg_i, busy, 1'b0, 1'b0, ~s.run_pull};
				4'h9: n.rdata = {15'h0000, s.phase == trim_track_pkg::PH_SYNC_WAIT};
				4'hA: n.rdata = {8'h00, s.fault, s.oe, s.con, s.done};
				4'hB: n.rdata = {12'h000, s.retrig, s.rpt};
				default: n.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s          <= '0;
			s.run_pull <= trim_track_pkg::RUN_PULL_RST;
		end else begin
			s <= n;
		end
	end

endmodule

// *** trim_track_pkg.sv ***
// Purpose: Shared constants and types for the trim servo and tracking link
// Assumes: 200 MHz reference clock, one synchronous active-high reset
// Notes:   Both ends use the same register map on the command link
package trim_track_pkg;

	localparam int CLK_NS = 5;

	// Device register indices on the command link
	localparam logic [3:0] A_IDAC0     = 4'h0;
	localparam logic [3:0] A_TRACK0    = 4'h2;
	localparam logic [3:0] A_TRACK1    = 4'h3;
	localparam logic [3:0] A_DELAY0    = 4'h4;
	localparam logic [3:0] A_DELAY1    = 4'h5;
	localparam logic [3:0] A_SERVO0    = 4'h6;
	localparam logic [3:0] A_IO        = 4'h8;
	localparam logic [3:0] A_SYNC      = 4'h9;
	localparam logic [3:0] A_STATUS    = 4'hA;
	localparam logic [3:0] A_SERVO_OPT = 4'hB;

	// Field positions
	localparam int IDAC_POL  = 8;
	localparam int IDAC_CON  = 9;
	localparam int IDAC_EN   = 10;
	localparam int TRK_POL   = 8;
	localparam int TRK_EN    = 9;
	localparam int SERVO_EN  = 15;
	localparam int IO_START  = 2;
	localparam int SYNC_REQ  = 0;

	// Reset values
	localparam logic [1:0] RUN_PULL_RST = 2'h3;

	// Times in ns and their cycle counts
	localparam int TRACK_STEP_NS   = 1000;
	localparam int TRACK_HOLD_NS   = 10000;
	localparam int TRACK_SETTLE_NS = 5000;
	localparam int SYNC_WAIT_NS    = 20000;
	localparam int RUN_WAIT_NS     = 2000;
	localparam int TRACK_STEP_CYC   = (TRACK_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRACK_HOLD_CYC   = (TRACK_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRACK_SETTLE_CYC = (TRACK_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_WAIT_CYC    = (SYNC_WAIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int RUN_WAIT_CYC     = (RUN_WAIT_NS + CLK_NS - 1) / CLK_NS;

	// Precise conversions at the target before servo is done
	localparam logic [1:0] FINE_CONVS = 2'h2;

	// Host user-side register addresses
	localparam logic [4:0] H_OFF   = 5'h10;
	localparam logic [4:0] H_TGT   = 5'h11;
	localparam logic [4:0] H_DLY   = 5'h12;
	localparam logic [4:0] H_CMD   = 5'h13;
	localparam logic [4:0] H_SERVO = 5'h14;
	localparam logic [4:0] H_PEEK  = 5'h15;
	localparam int HC_PWRUP = 0;
	localparam int HC_SERVO = 1;
	localparam int HC_SCH   = 2;
	localparam int HC_POL   = 3;
	localparam logic [3:0] SEQ_RUN_STEP = 4'h6;

	typedef enum logic [2:0] {PH_IDLE, PH_SYNC_FINISH, PH_SYNC_WAIT, PH_SETTLE, PH_STEP, PH_HOLD} phase_t;
	typedef enum logic [1:0] {HM_IDLE, HM_PWR, HM_WAIT, HM_SRV} host_mode_t;

endpackage

// *** trim_link_if.sv ***
// Purpose: Command link between the host controller and the trim device
// Assumes: Read data returns the cycle after the read strobe
// Notes:   No clocking block; both ends share ref_clk_i
`timescale 1ns/1ps
interface trim_link_if;
	logic        wr;
	logic        rd;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport host (output wr, rd, addr, wdata, input rdata);
	modport dev  (input wr, rd, addr, wdata, output rdata);
endinterface

// *** trim_track_host.sv ***
// Purpose: Host end that drives the trim device command link
// Assumes: User port with read data one cycle after the read strobe
// Notes:   Runs canned power-up tracking and one-time servo sequences
`timescale 1ns/1ps
module trim_track_host #(
	parameter int RUN_CYC = trim_track_pkg::RUN_WAIT_CYC
) (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	trim_link_if.host        link,
	input  wire logic [4:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o
);

	typedef struct packed {
		logic [15:0] off;
		logic [15:0] tgt;
		logic [15:0] dly;
		logic [14:0] starget;
		logic [1:0]  pol;
		logic        sch;
		trim_track_pkg::host_mode_t mode;
		logic [3:0]  step;
		logic [11:0] tmr;
		logic        cap;
		logic [15:0] peek;
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
	} hstate_t;

	hstate_t     s;
	hstate_t     n;
	logic [3:0]  sa;
	logic [15:0] sd;
	logic        last;

	assign link.wr    = s.wr;
	assign link.rd    = s.rd;
	assign link.addr  = s.addr;
	assign link.wdata = s.wdata;
	assign rdata_o    = s.rdata;

	always_comb begin
		n     = s;
		n.wr  = 1'b0;
		n.rd  = 1'b0;
		n.cap = s.rd;
		sa    = '0;
		sd    = '0;
		last  = 1'b0;
		if (s.cap) begin
			n.peek = link.rdata;
		end
		if (s.mode == trim_track_pkg::HM_PWR) begin
			unique case (s.step)
				4'h0, 4'h1: begin
					sa = trim_track_pkg::A_IDAC0 + {3'h0, s.step[0]};
					sd = {5'h00, 1'b1, 1'b1, s.pol[s.step[0]], s.off[8*s.step[0] +: 8]};
				end
				4'h2, 4'h3: begin
					sa = trim_track_pkg::A_TRACK0 + {3'h0, s.step[0]};
					sd = {6'h00, 1'b1, 1'b0, s.tgt[8*s.step[0] +: 8]};
				end
				4'h4, 4'h5: begin
					sa = trim_track_pkg::A_DELAY0 + {3'h0, s.step[0]};
					sd = {8'h00, s.dly[8*s.step[0] +: 8]};
				end
				4'h6: begin
					sa = trim_track_pkg::A_IO;
					sd = 16'h0003;
				end
				default: begin
					sa   = trim_track_pkg::A_IO;
					sd   = 16'h0007;
					last = 1'b1;
				end
			endcase
		end else begin
			sa   = s.step[0] ? trim_track_pkg::A_SERVO0 + {3'h0, s.sch} : trim_track_pkg::A_SERVO_OPT;
			sd   = s.step[0] ? {1'b1, s.starget} : 16'h0000;
			last = s.step[0];
		end
		unique case (s.mode)
			trim_track_pkg::HM_IDLE: begin
			end
			trim_track_pkg::HM_PWR, trim_track_pkg::HM_SRV: begin
				n.wr    = 1'b1;
				n.addr  = sa;
				n.wdata = sd;
				n.step  = s.step + 4'h1;
				if (last) begin
					n.mode = trim_track_pkg::HM_IDLE;
				end else if (s.mode == trim_track_pkg::HM_PWR && s.step == trim_track_pkg::SEQ_RUN_STEP) begin
					n.mode = trim_track_pkg::HM_WAIT;
					n.tmr  = '0;
				end
			end
			trim_track_pkg::HM_WAIT: begin
				n.tmr = s.tmr + 12'h001;
				if (s.tmr == 12'(RUN_CYC - 1)) begin
					n.mode = trim_track_pkg::HM_PWR;
				end
			end
		endcase
		if (wr_i) begin
			unique case (addr_i)
				trim_track_pkg::H_OFF:   n.off     = wdata_i;
				trim_track_pkg::H_TGT:   n.tgt     = wdata_i;
				trim_track_pkg::H_DLY:   n.dly     = wdata_i;
				trim_track_pkg::H_SERVO: n.starget = wdata_i[14:0];
				trim_track_pkg::H_CMD: begin
					if (s.mode == trim_track_pkg::HM_IDLE) begin
						n.pol  = wdata_i[trim_track_pkg::HC_POL +: 2];
						n.sch  = wdata_i[trim_track_pkg::HC_SCH];
						n.step = '0;
						if (wdata_i[trim_track_pkg::HC_PWRUP]) begin
							n.mode = trim_track_pkg::HM_PWR;
						end else if (wdata_i[trim_track_pkg::HC_SERVO]) begin
							n.mode = trim_track_pkg::HM_SRV;
						end
					end
				end
				trim_track_pkg::H_PEEK: begin
					if (s.mode == trim_track_pkg::HM_IDLE) begin
						n.rd   = 1'b1;
						n.addr = wdata_i[3:0];
					end
				end
				default: begin
					if (!addr_i[4] && s.mode == trim_track_pkg::HM_IDLE) begin
						n.wr    = 1'b1;
						n.addr  = addr_i[3:0];
						n.wdata = wdata_i;
					end
				end
			endcase
		end
		n.rdata = '0;
		if (rd_i) begin
			unique case (addr_i)
				trim_track_pkg::H_OFF:   n.rdata = s.off;
				trim_track_pkg::H_TGT:   n.rdata = s.tgt;
				trim_track_pkg::H_DLY:   n.rdata = s.dly;
				trim_track_pkg::H_SERVO: n.rdata = {1'b0, s.starget};
				trim_track_pkg::H_CMD:   n.rdata = {15'h0000, s.mode != trim_track_pkg::HM_IDLE};
				trim_track_pkg::H_PEEK:  n.rdata = s.peek;
				default:                 n.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule

// *** supply_trim_track_servo_sva.sv ***
// Purpose: Assertions on the trim link and the device outputs
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Instantiated beside the link by the bench
`timescale 1ns/1ps
module trim_link_checker #(
	parameter int HOLD_CYC = 8
) (
	input wire logic            ref_clk_i,
	input wire logic            reset_i,
	input wire logic            wr,
	input wire logic [3:0]      addr,
	input wire logic [15:0]     wdata,
	input wire logic            adc_done_i,
	input wire logic            adc_ch_i,
	input wire logic [14:0]     adc_value_i,
	input wire logic            cfg_i,
	input wire logic [1:0]      run_i,
	input wire logic [1:0][7:0] trim_code_o,
	input wire logic [1:0]      trim_oe_o,
	input wire logic            adc_fast_o,
	input wire logic            adc_hold_others_o,
	input wire logic            adc_hold_all_o,
	input wire logic [1:0]      run_oe_o,
	input wire logic            cfg_oe_o
);
	localparam int HOLD_LO = HOLD_CYC - 5;
	localparam int HOLD_HI = HOLD_CYC - 1;
	logic        range_on;
	logic        idac0_wr;
	logic        conv0;
	logic [14:0] servo_tgt;
	logic        rpt0;

	assign range_on = cfg_i && run_i != 2'b00;
	assign idac0_wr = wr && addr == trim_track_pkg::A_IDAC0;
	assign conv0    = adc_done_i && !adc_ch_i && adc_fast_o && !wr;

	// Servo target and repeat bit of channel 0 as last written on the link
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			servo_tgt <= 15'h0000;
			rpt0      <= 1'b0;
		end else begin
			if (wr && addr == trim_track_pkg::A_SERVO0) begin
				servo_tgt <= wdata[14:0];
			end
			if (wr && addr == trim_track_pkg::A_SERVO_OPT) begin
				rpt0 <= wdata[0];
			end
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	disable_oe_a: assert property (idac0_wr && !wdata[trim_track_pkg::IDAC_EN] && !range_on |=> !trim_oe_o[0])
		else $error("trim output still driven after disable");
	con_keep_a: assert property (idac0_wr && wdata[trim_track_pkg::IDAC_EN] && trim_oe_o[0] |=> trim_oe_o[0])
		else $error("trim output dropped while enable high");
	oe_frozen_a: assert property (range_on |=> $stable(trim_oe_o))
		else $error("output enable changed in tracking range");
	run_held_a: assert property ($fell(reset_i) |-> run_oe_o == trim_track_pkg::RUN_PULL_RST)
		else $error("run wires not held low after reset");
	hold_off_a: assert property ($rose(cfg_oe_o) |-> (trim_oe_o != 2'b00) [*4] ##[HOLD_LO:HOLD_HI] trim_oe_o == 2'b00)
		else $error("enables not cleared after hold delay");
	servo_up_a: assert property (conv0 && $signed(adc_value_i) < $signed(servo_tgt) && trim_code_o[0] != 8'hFF
		|=> trim_code_o[0] == $past(trim_code_o[0]) + 8'h01)
		else $error("servo did not step code up");
	servo_down_a: assert property (conv0 && $signed(adc_value_i) > $signed(servo_tgt) && trim_code_o[0] != 8'h00
		|=> trim_code_o[0] == $past(trim_code_o[0]) - 8'h01)
		else $error("servo did not step code down");
	servo_off_a: assert property ((trim_oe_o == 2'b00) [*2] |-> !adc_hold_others_o)
		else $error("servo active on disabled output");
	servo_start_a: assert property (wr && addr == trim_track_pkg::A_SERVO0 && wdata[trim_track_pkg::SERVO_EN] && trim_oe_o[0]
		&& !adc_hold_all_o && !range_on |=> adc_fast_o && adc_hold_others_o)
		else $error("servo write did not start fast phase");
	fast_hold_a: assert property (adc_fast_o |-> adc_hold_others_o)
		else $error("other conversions not held in fast phase");
	range_servo_a: assert property (range_on [*2] |-> !adc_fast_o)
		else $error("servo kept in tracking range");
	done_stop_a: assert property (adc_done_i && !adc_ch_i && !adc_hold_others_o && !adc_hold_all_o && !rpt0 && !wr
		|=> $stable(trim_code_o[0]))
		else $error("code moved after servo done");
endmodule

// *** supply_trim_track_servo_bench.sv ***
// Purpose: Self-checking bench for the host and trim device pair
// Assumes: Short delay counts, pull-ups on run and config wires
// Notes:   Host user port drives the device over the link
`timescale 1ns/1ps
module supply_trim_track_servo_bench;
	localparam int HOLD = 8;
	localparam int SYNC = 40;
	logic            ref_clk_i;
	logic            reset_i;
	logic [4:0]      addr_i;
	logic [15:0]     wdata_i;
	logic            wr_i;
	logic            rd_i;
	logic [15:0]     rdata_o;
	logic            adc_done_i;
	logic            adc_ch_i;
	logic [14:0]     adc_value_i;
	logic            adc_busy_i;
	logic            cfg_i;
	logic [1:0]      run_i;
	logic [1:0][7:0] trim_code_o;
	logic [1:0]      trim_oe_o;
	logic [1:0]      idac_fault_o;
	logic            adc_fast_o;
	logic            adc_hold_others_o;
	logic            adc_hold_all_o;
	logic [1:0]      run_oe_o;
	logic            cfg_oe_o;
	int              n_mismatch;
	int              cmp_count;

	trim_link_if trim_link_if_inst ();

	// Open-drain wires with pull-ups
	assign cfg_i = ~cfg_oe_o;
	assign run_i = ~run_oe_o;

	supply_trim_track_servo #(
		.STEP_CYC   (8),
		.HOLD_CYC   (HOLD),
		.SETTLE_CYC (6),
		.SYNC_CYC   (SYNC)
	) supply_trim_track_servo_inst (
		.ref_clk_i         (ref_clk_i),
		.reset_i           (reset_i),
		.link              (trim_link_if_inst),
		.adc_done_i        (adc_done_i),
		.adc_ch_i          (adc_ch_i),
		.adc_value_i       (adc_value_i),
		.adc_busy_i        (adc_busy_i),
		.volt_fault_i      (2'b00),
		.soft_conn_i       (2'b00),
		.cfg_i             (cfg_i),
		.run_i             (run_i),
		.trim_code_o       (trim_code_o),
		.trim_oe_o         (trim_oe_o),
		.idac_fault_o      (idac_fault_o),
		.adc_fast_o        (adc_fast_o),
		.adc_hold_others_o (adc_hold_others_o),
		.adc_hold_all_o    (adc_hold_all_o),
		.run_o             (),
		.run_oe_o          (run_oe_o),
		.cfg_o             (),
		.cfg_oe_o          (cfg_oe_o)
	);

	trim_track_host #(
		.RUN_CYC (8)
	) trim_track_host_inst (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.link      (trim_link_if_inst),
		.addr_i    (addr_i),
		.wdata_i   (wdata_i),
		.wr_i      (wr_i),
		.rd_i      (rd_i),
		.rdata_o   (rdata_o)
	);

	trim_link_checker #(
		.HOLD_CYC (HOLD)
	) trim_link_checker_inst (
		.ref_clk_i         (ref_clk_i),
		.reset_i           (reset_i),
		.wr                (trim_link_if_inst.wr),
		.addr              (trim_link_if_inst.addr),
		.wdata             (trim_link_if_inst.wdata),
		.adc_done_i        (adc_done_i),
		.adc_ch_i          (adc_ch_i),
		.adc_value_i       (adc_value_i),
		.cfg_i             (cfg_i),
		.run_i             (run_i),
		.trim_code_o       (trim_code_o),
		.trim_oe_o         (trim_oe_o),
		.adc_fast_o        (adc_fast_o),
		.adc_hold_others_o (adc_hold_others_o),
		.adc_hold_all_o    (adc_hold_all_o),
		.run_oe_o          (run_oe_o),
		.cfg_oe_o          (cfg_oe_o)
	);

	always #(trim_track_pkg::CLK_NS / 2.0) ref_clk_i = ~ref_clk_i;

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic hw(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic hr(input logic [4:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic dw(input logic [3:0] a, input logic [15:0] d);
		hw({1'b0, a}, d);
		cyc(2);
	endtask

	task automatic pk(input logic [3:0] idx, input logic [15:0] exp);
		logic [15:0] d;
		hw(trim_track_pkg::H_PEEK, {12'h000, idx});
		cyc(3);
		hr(trim_track_pkg::H_PEEK, d);
		chk(d, exp);
	endtask

	task automatic conv(input logic [14:0] v, input logic [7:0] code, input logic [1:0] flags);
		@(posedge ref_clk_i);
		adc_done_i  <= 1'b1;
		adc_value_i <= v;
		@(posedge ref_clk_i);
		adc_done_i <= 1'b0;
		cyc(1);
		chk({trim_code_o[0], 6'h00, adc_fast_o, adc_hold_others_o}, {code, 6'h00, flags});
	endtask

	task automatic stop_test;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		cyc(20000);
		n_mismatch++;
		stop_test();
	end

	initial begin
		logic [15:0] d;
		int          i;
		ref_clk_i   = 1'b0;
		reset_i     = 1'b1;
		addr_i      = 5'h00;
		wdata_i     = 16'h0000;
		wr_i        = 1'b0;
		rd_i        = 1'b0;
		adc_done_i  = 1'b0;
		adc_ch_i    = 1'b0;
		adc_value_i = 15'h0000;
		adc_busy_i  = 1'b1;
		n_mismatch  = 0;
		cmp_count   = 0;
		repeat (8) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		cyc(2);
		chk({12'h000, idac_fault_o, run_oe_o}, 16'h000F);
		// Sync waits for the conversion, then times out
		dw(trim_track_pkg::A_SYNC, 16'h0001);
		pk(trim_track_pkg::A_SYNC, 16'h0000);
		chk({15'h0000, adc_hold_all_o}, 16'h0001);
		@(posedge ref_clk_i);
		adc_busy_i <= 1'b0;
		pk(trim_track_pkg::A_SYNC, 16'h0001);
		cyc(SYNC + 5);
		pk(trim_track_pkg::A_SYNC, 16'h0000);
		// Start refused with an unconnected channel
		dw(trim_track_pkg::A_TRACK0, 16'h0220);
		dw(trim_track_pkg::A_IO, 16'h0004);
		cyc(20);
		chk(trim_code_o, 16'h0000);
		pk(trim_track_pkg::A_IO, 16'h0020);
		dw(trim_track_pkg::A_TRACK0, 16'h0000);
		// Power-up tracking from the host
		hw(trim_track_pkg::H_OFF, 16'h1210);
		hw(trim_track_pkg::H_TGT, 16'h1114);
		hw(trim_track_pkg::H_DLY, 16'h0600);
		hw(trim_track_pkg::H_CMD, 16'h0001);
		for (i = 0; i < 40; i++) begin
			hr(trim_track_pkg::H_CMD, d);
			if (d[0] === 1'b0) break;
		end
		dw(trim_track_pkg::A_IDAC0, 16'h0210);
		chk({14'h0000, trim_oe_o}, 16'h0003);
		dw(trim_track_pkg::A_TRACK0, 16'h0230);
		for (i = 0; i < 300 && cfg_oe_o !== 1'b1; i++) cyc(1);
		chk(trim_code_o, 16'h1114);
		chk({14'h0000, trim_oe_o}, 16'h0003);
		cyc(HOLD + 2);
		chk({14'h0000, trim_oe_o}, 16'h0000);
		// Power-down tracking
		dw(trim_track_pkg::A_TRACK0, 16'h0210);
		dw(trim_track_pkg::A_TRACK1, 16'h020E);
		dw(trim_track_pkg::A_DELAY1, 16'h0001);
		dw(trim_track_pkg::A_IDAC0, 16'h0614);
		dw(trim_track_pkg::A_IDAC0, 16'h0414);
		chk({14'h0000, trim_oe_o}, 16'h0001);
		dw(trim_track_pkg::A_IO, 16'h0007);
		cyc(4);
		chk({15'h0000, cfg_oe_o}, 16'h0001);
		dw(trim_track_pkg::A_IDAC0, 16'h0014);
		chk({14'h0000, trim_oe_o}, 16'h0000);
		dw(trim_track_pkg::A_IO, 16'h0007);
		chk({13'h0000, cfg_oe_o, trim_oe_o}, 16'h0003);
		for (i = 0; i < 300 && trim_code_o !== 16'h0E10; i++) cyc(1);
		cyc(12);
		chk(trim_code_o, 16'h0E10);
		pk(trim_track_pkg::A_TRACK0, 16'h0010);
		pk(trim_track_pkg::A_TRACK1, 16'h000E);
		// One-time servo on channel 0
		dw(trim_track_pkg::A_IO, 16'h0000);
		hw(trim_track_pkg::H_SERVO, 16'h0100);
		hw(trim_track_pkg::H_CMD, 16'h0002);
		cyc(5);
		chk({14'h0000, adc_fast_o, adc_hold_others_o}, 16'h0003);
		@(posedge ref_clk_i);
		adc_ch_i <= 1'b1;
		conv(15'h0080, 8'h10, 2'b11);
		@(posedge ref_clk_i);
		adc_ch_i <= 1'b0;
		conv(15'h0080, 8'h11, 2'b11);
		conv(15'h0200, 8'h10, 2'b11);
		conv(15'h0100, 8'h10, 2'b01);
		conv(15'h0100, 8'h10, 2'b01);
		conv(15'h0100, 8'h10, 2'b00);
		conv(15'h0080, 8'h10, 2'b00);
		stop_test();
	end
endmodule
